// [logic/pin_sync.sv]
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             srst,
    // Pins and synchronised levels
    input  wire logic [WIDTH-1:0] pinIn,
    output var  logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage1_next;
    logic [WIDTH-1:0] syncOut_next;

    always_comb begin
        stage1_next  = pinIn;
        syncOut_next = stage1_reg;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            stage1_reg <= '1;
            syncOut    <= '1;
        end else begin
            stage1_reg <= stage1_next;
            syncOut    <= syncOut_next;
        end
    end

endmodule

`default_nettype wire

// [logic/synth_cal_test_regs.sv]
// Synthesizer calibration, test and chip-id registers behind the serial port
//
// Overview of operation
// - Coarse-tune result is a 6-bit field, reset 0x20, top bits unused.
// - Writing saved results replaces calibration; synthesizer uses the written values, except that a calibration result in the same cycle wins.
// - Production-test value 0xBF exposes the temperature sensor while idle.
// - Third test register bit 1 enables VCO-selection calibration; resets to 1.
// - Calibration control is a 7-bit field, reset 0x0D, bit 7 reserved.
// - Part-number status register at 0x30, read with header 0xF0.
// - Silicon revision status register at 0x31, read with header 0xF1.
`timescale 1ns/1ps
`default_nettype none
`include "synth_regs_cfg.svh"

module synth_cal_test_regs #(
    parameter logic [7:0] PART_ID = `PART_ID_DEFAULT,
    parameter logic [7:0] REV_ID  = `REV_ID_DEFAULT
) (
    // Clock and reset
    input  wire logic                 clock,
    input  wire logic                 srst,
    // Serial configuration port pins
    input  wire logic                 sclkPin,
    input  wire logic                 chipSelectN,
    input  wire logic                 serialIn,
    output var  logic                 serialOut,
    output var  logic                 serialOutOe,
    // Calibration engine and radio state
    input  wire logic                 calUpdate,
    input  wire logic [`COARSE_W-1:0] calCoarseResult,
    input  wire logic                 radioIdle,
    // Settings to the synthesizer and test logic
    output var  logic [`COARSE_W-1:0]  vcoCoarseTune,
    output var  logic [`CONTROL_W-1:0] synthCalControl,
    output var  logic                  vcoSelectStageEnable,
    output var  logic [7:0]            synthFactoryTest,
    output var  logic [7:0]            productionTest,
    output var  logic [7:0]            testSettingsA,
    output var  logic [7:0]            testSettingsB,
    output var  logic [7:0]            testSettingsC,
    output var  logic                  tempSensorEnable
);

    // Pin synchronisation
    logic [2:0] pinsSync;
    logic       sclkSync;
    logic       csnSync;
    logic       siSync;

    pin_sync #(
        .WIDTH(3)
    ) u_pin_sync (
        .clock  (clock),
        .srst   (srst),
        .pinIn  ({sclkPin, chipSelectN, serialIn}),
        .syncOut(pinsSync)
    );

    assign sclkSync = pinsSync[2];
    assign csnSync  = pinsSync[1];
    assign siSync   = pinsSync[0];

    // Port state
    synth_regs_pkg::port_state_e state_reg;
    synth_regs_pkg::port_state_e state_next;
    synth_regs_pkg::header_s     header_reg;
    synth_regs_pkg::header_s     header_next;
    logic [2:0]                  bitCnt_reg;
    logic [2:0]                  bitCnt_next;
    logic [7:0]                  rxShift_reg;
    logic [7:0]                  rxShift_next;
    logic [7:0]                  txShift_reg;
    logic [7:0]                  txShift_next;
    logic                        sclkPrev_reg;
    logic                        sclkPrev_next;
    logic                        serialOut_next;
    logic                        serialOutOe_next;

    // Write request towards the register group
    logic                        wrEn;
    logic [5:0]                  wrAddr;
    logic [7:0]                  wrData;

    // Register group
    synth_regs_pkg::cfg_regs_s   regs_reg;
    synth_regs_pkg::cfg_regs_s   regs_next;
    logic                        tempSensorEnable_next;

    logic                        sclkRise;
    logic                        sclkFall;
    logic [7:0]                  rxByte;
    synth_regs_pkg::header_s     rxHeader;
    logic [5:0]                  nextAddr;

    assign sclkRise = sclkSync & ~sclkPrev_reg & ~csnSync;
    assign sclkFall = ~sclkSync & sclkPrev_reg & ~csnSync;
    assign rxByte   = {rxShift_reg[6:0], siSync};
    assign rxHeader = synth_regs_pkg::header_s'(rxByte);

    // Read data for one access
    function automatic logic [7:0] readValue(
        input synth_regs_pkg::header_s   hdr,
        input synth_regs_pkg::cfg_regs_s regs
    );
        logic [7:0] value;
        value = 8'h00;
        if (hdr.burst && hdr.addr >= `ADDR_STATUS_BASE) begin
            unique case (hdr.addr)
                `ADDR_PART_NUMBER: value = PART_ID;
                `ADDR_SILICON_REV: value = REV_ID;
                default:           value = 8'h00;
            endcase
        end else begin
            unique case (hdr.addr)
                `ADDR_COARSE_TUNE:  value = {2'h0, regs.coarseTune};
                `ADDR_CAL_CONTROL:  value = {1'h0, regs.calControl};
                `ADDR_FACTORY_TEST: value = regs.factoryTest;
                `ADDR_PROD_TEST:    value = regs.productionTest;
                `ADDR_TEST_C:       value = regs.testC;
                `ADDR_TEST_B:       value = regs.testB;
                `ADDR_TEST_A:       value = regs.testA;
                default:            value = 8'h00;
            endcase
        end
        return value;
    endfunction

    // Serial port: header, data bytes and read shift-out
    always_comb begin
        state_next       = state_reg;
        header_next      = header_reg;
        bitCnt_next      = bitCnt_reg;
        rxShift_next     = rxShift_reg;
        txShift_next     = txShift_reg;
        sclkPrev_next    = sclkSync;
        serialOut_next   = serialOut;
        serialOutOe_next = ~csnSync;
        wrEn             = 1'b0;
        wrAddr           = header_reg.addr;
        wrData           = rxByte;
        nextAddr         = header_reg.addr;
        if (csnSync) begin
            state_next     = synth_regs_pkg::PORT_IDLE;
            bitCnt_next    = 3'h0;
            txShift_next   = 8'h00;
            serialOut_next = 1'b0;
        end else begin
            unique case (state_reg)
                synth_regs_pkg::PORT_IDLE: begin
                    state_next  = synth_regs_pkg::PORT_HEADER;
                    bitCnt_next = 3'h0;
                end
                synth_regs_pkg::PORT_HEADER,
                synth_regs_pkg::PORT_DATA: begin
                    if (sclkRise) begin
                        rxShift_next = rxByte;
                        bitCnt_next  = bitCnt_reg + 3'h1;
                        if (bitCnt_reg == `LAST_BIT_INDEX) begin
                            if (state_reg == synth_regs_pkg::PORT_HEADER) begin
                                header_next = rxHeader;
                                state_next  = synth_regs_pkg::PORT_DATA;
                                if (rxHeader.readNotWrite) begin
                                    txShift_next = readValue(rxHeader, regs_reg);
                                end
                            end else begin
                                if (header_reg.burst && header_reg.addr < `ADDR_STATUS_BASE) begin
                                    nextAddr = header_reg.addr + `ADDR_STEP;
                                end
                                header_next.addr = nextAddr;
                                if (header_reg.readNotWrite) begin
                                    txShift_next = readValue(header_next, regs_reg);
                                end else begin
                                    wrEn = header_reg.addr < `ADDR_STATUS_BASE;
                                end
                            end
                        end
                    end else if (sclkFall) begin
                        serialOut_next = txShift_reg[7];
                        txShift_next   = {txShift_reg[6:0], 1'b0};
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            state_reg    <= synth_regs_pkg::PORT_IDLE;
            header_reg   <= '0;
            bitCnt_reg   <= 3'h0;
            rxShift_reg  <= 8'h00;
            txShift_reg  <= 8'h00;
            sclkPrev_reg <= 1'b0;
            serialOut    <= 1'b0;
            serialOutOe  <= 1'b0;
        end else begin
            state_reg    <= state_next;
            header_reg   <= header_next;
            bitCnt_reg   <= bitCnt_next;
            rxShift_reg  <= rxShift_next;
            txShift_reg  <= txShift_next;
            sclkPrev_reg <= sclkPrev_next;
            serialOut    <= serialOut_next;
            serialOutOe  <= serialOutOe_next;
        end
    end

    // Register group: host writes and calibration results
    always_comb begin
        regs_next = regs_reg;
        if (wrEn) begin
            unique case (wrAddr)
                `ADDR_COARSE_TUNE:  regs_next.coarseTune = wrData[`COARSE_W-1:0];
                `ADDR_CAL_CONTROL:  regs_next.calControl = wrData[`CONTROL_W-1:0];
                `ADDR_FACTORY_TEST: regs_next.factoryTest = wrData;
                `ADDR_PROD_TEST:    regs_next.productionTest = wrData;
                `ADDR_TEST_C:       regs_next.testC = wrData;
                `ADDR_TEST_B:       regs_next.testB = wrData;
                `ADDR_TEST_A:       regs_next.testA = wrData;
                default:            regs_next = regs_reg;
            endcase
        end
        if (calUpdate) begin
            regs_next.coarseTune = calCoarseResult;
        end
        tempSensorEnable_next = (regs_reg.productionTest == `TEMP_SENSOR_CODE) && radioIdle;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            regs_reg.coarseTune     <= `RST_COARSE_TUNE;
            regs_reg.calControl     <= `RST_CAL_CONTROL;
            regs_reg.factoryTest    <= `RST_FACTORY_TEST;
            regs_reg.productionTest <= `RST_PROD_TEST;
            regs_reg.testC          <= `RST_TEST_C;
            regs_reg.testB          <= `RST_TEST_B;
            regs_reg.testA          <= `RST_TEST_A;
            tempSensorEnable        <= 1'b0;
        end else begin
            regs_reg         <= regs_next;
            tempSensorEnable <= tempSensorEnable_next;
        end
    end

    assign vcoCoarseTune        = regs_reg.coarseTune;
    assign synthCalControl      = regs_reg.calControl;
    assign vcoSelectStageEnable = regs_reg.testA[`VCO_SEL_BIT];
    assign synthFactoryTest     = regs_reg.factoryTest;
    assign productionTest       = regs_reg.productionTest;
    assign testSettingsA        = regs_reg.testA;
    assign testSettingsB        = regs_reg.testB;
    assign testSettingsC        = regs_reg.testC;

endmodule

`default_nettype wire

// [logic/synth_regs_cfg.svh]
// Constants for the synthesizer calibration and test register slice
`ifndef SYNTH_REGS_CFG_SVH
`define SYNTH_REGS_CFG_SVH

// Register addresses on the serial port
`define ADDR_COARSE_TUNE    6'h25
`define ADDR_CAL_CONTROL    6'h26
`define ADDR_FACTORY_TEST   6'h29
`define ADDR_PROD_TEST      6'h2a
`define ADDR_TEST_C         6'h2c
`define ADDR_TEST_B         6'h2d
`define ADDR_TEST_A         6'h2e
`define ADDR_STATUS_BASE    6'h30
`define ADDR_PART_NUMBER    6'h30
`define ADDR_SILICON_REV    6'h31

// Field widths and the VCO-select bit position
`define COARSE_W            6
`define CONTROL_W           7
`define VCO_SEL_BIT         1

// Reset values
`define RST_COARSE_TUNE     6'h20
`define RST_CAL_CONTROL     7'h0d
`define RST_FACTORY_TEST    8'h57
`define RST_PROD_TEST       8'h7f
`define RST_TEST_C          8'h00
`define RST_TEST_B          8'h21
`define RST_TEST_A          8'h0b

// Production-test code that exposes the temperature sensor
`define TEMP_SENSOR_CODE    8'hbf

// Identity codes, values arbitrary
`define PART_ID_DEFAULT     8'h5a
`define REV_ID_DEFAULT      8'h0c

// Header byte layout
`define HDR_READ_BIT        7
`define HDR_BURST_BIT       6
`define LAST_BIT_INDEX      3'h7
`define ADDR_STEP           6'h01

`endif

// [logic/synth_regs_pkg.sv]
// Types shared by the synthesizer calibration and test register slice
`default_nettype none
`include "synth_regs_cfg.svh"

package synth_regs_pkg;

    typedef struct packed {
        logic [`COARSE_W-1:0]  coarseTune;
        logic [`CONTROL_W-1:0] calControl;
        logic [7:0]            factoryTest;
        logic [7:0]            productionTest;
        logic [7:0]            testC;
        logic [7:0]            testB;
        logic [7:0]            testA;
    } cfg_regs_s;

    typedef struct packed {
        logic       readNotWrite;
        logic       burst;
        logic [5:0] addr;
    } header_s;

    typedef enum logic [1:0] {
        PORT_IDLE   = 2'b00,
        PORT_HEADER = 2'b01,
        PORT_DATA   = 2'b11
    } port_state_e;

endpackage

`default_nettype wire

// [sim/spi_host_model.sv]
// Host model: serial-port master driving the register slice
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
    // Clock
    input  wire logic       clock,
    // Serial port pins
    output var  logic       sclkPin,
    output var  logic       chipSelectN,
    output var  logic       serialIn,
    input  wire logic       serialOut,
    // Read results
    output var  logic       rdDone,
    output var  logic [7:0] rdByte
);
    localparam int HALF = 8;

    initial begin
        sclkPin = 1'b0;
        chipSelectN = 1'b1;
        serialIn = 1'b0;
        rdDone = 1'b0;
        rdByte = 8'h00;
    end

    task automatic xfer(input logic [7:0] hdr, input logic [7:0] wr, input int nBits);
        logic [23:0] frame;
        frame = {hdr, wr, wr};
        @(negedge clock);
        chipSelectN = 1'b0;
        repeat (HALF) @(negedge clock);
        for (int i = 23; i > 23 - nBits; i--) begin
            serialIn = frame[i];
            repeat (HALF) @(negedge clock);
            sclkPin = 1'b1;
            // Last eight sampled bits form the final data byte
            rdByte = {rdByte[6:0], serialOut};
            repeat (HALF) @(negedge clock);
            sclkPin = 1'b0;
        end
        repeat (2 * HALF) @(negedge clock);
        chipSelectN = 1'b1;
        // Released data line flips so a stale level is never seen
        serialIn = ~serialIn;
        rdDone = hdr[7] && nBits >= 16;
        @(negedge clock);
        rdDone = 1'b0;
    endtask
endmodule

`default_nettype wire

// [sim/synth_cal_test_regs_chk.sv]
// Checker for the calibration and test register slice
`timescale 1ns/1ps
`default_nettype none

module synth_cal_test_regs_chk (
    // Clock and reset
    input wire logic       clock,
    input wire logic       srst,
    // Watched ports
    input wire logic       chipSelectN,
    input wire logic       serialOut,
    input wire logic       serialOutOe,
    input wire logic       calUpdate,
    input wire logic [5:0] calCoarseResult,
    input wire logic       radioIdle,
    input wire logic [5:0] vcoCoarseTune,
    input wire logic [6:0] synthCalControl,
    input wire logic       vcoSelectStageEnable,
    input wire logic [7:0] productionTest,
    input wire logic [7:0] testSettingsA,
    input wire logic [7:0] testSettingsB,
    input wire logic       tempSensorEnable
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    reset_defaults_a: assert property (disable iff (1'b0)
        srst |=> vcoCoarseTune == 6'h20 && synthCalControl == 7'h0d
        && productionTest == 8'h7f && testSettingsB == 8'h21 && !serialOutOe)
        else $error("reset values wrong");
    cal_load_a: assert property (
        calUpdate |=> vcoCoarseTune == $past(calCoarseResult))
        else $error("calibration result not loaded");
    vco_sel_a: assert property (disable iff (1'b0)
        srst |=> vcoSelectStageEnable && testSettingsA[1])
        else $error("vco select stage enable not set by reset");
    temp_sense_a: assert property (
        tempSensorEnable == ($past(productionTest) == 8'hbf && $past(radioIdle)))
        else $error("temperature sensor enable wrong");
    oe_timing_a: assert property (
        $fell(chipSelectN) |-> ##[2:5] serialOutOe)
        else $error("output enable late");
    oe_frame_a: assert property (
        (!chipSelectN)[*6] |-> serialOutOe)
        else $error("output enable dropped in frame");
    oe_idle_a: assert property (
        chipSelectN[*5] |-> !serialOutOe && !serialOut)
        else $error("serial output active while deselected");
    hold_idle_a: assert property (
        (chipSelectN[*8] ##0 !calUpdate) |=> $stable(vcoCoarseTune) && $stable(testSettingsB))
        else $error("register changed without access");
endmodule

bind synth_cal_test_regs synth_cal_test_regs_chk u_synth_cal_test_regs_chk (
    .clock, .srst, .chipSelectN, .serialOut, .serialOutOe, .calUpdate, .calCoarseResult,
    .radioIdle, .vcoCoarseTune, .synthCalControl, .vcoSelectStageEnable, .productionTest,
    .testSettingsA, .testSettingsB, .tempSensorEnable);

`default_nettype wire

// [sim/test_synth_cal_test_regs.sv]
// Testbench for the calibration and test register slice
`timescale 1ns/1ps
`default_nettype none
`include "synth_regs_cfg.svh"

module test_synth_cal_test_regs;
    localparam logic [7:0] PART = 8'h3c; // arbitrary
    localparam logic [7:0] REV  = 8'h19; // arbitrary
    localparam logic [63:0] DEF = {9'h0, `RST_COARSE_TUNE, `RST_CAL_CONTROL, 1'b1,
        `RST_FACTORY_TEST, `RST_PROD_TEST, `RST_TEST_A, `RST_TEST_B, `RST_TEST_C, 1'b0};
    localparam logic [7:0] ADDRS [7] = '{8'h25, 8'h26, 8'h29, 8'h2a, 8'h2c, 8'h2d, 8'h2e};
    localparam logic [7:0] EXPS  [7] = '{{2'h0, `RST_COARSE_TUNE}, {1'h0, `RST_CAL_CONTROL},
        `RST_FACTORY_TEST, `RST_PROD_TEST, `RST_TEST_C, `RST_TEST_B, `RST_TEST_A};
    logic       clock;
    logic       srst;
    logic       sclkPin;
    logic       chipSelectN;
    logic       serialIn;
    logic       serialOut;
    logic       serialOutOe;
    logic       calUpdate;
    logic [5:0] calCoarseResult;
    logic       radioIdle;
    logic [5:0] vcoCoarseTune;
    logic [6:0] synthCalControl;
    logic       vcoSelectStageEnable;
    logic [7:0] synthFactoryTest;
    logic [7:0] productionTest;
    logic [7:0] testSettingsA;
    logic [7:0] testSettingsB;
    logic [7:0] testSettingsC;
    logic       tempSensorEnable;
    logic       rdDone;
    logic [7:0] rdByte;
    logic [7:0] expQ[$];
    logic [7:0] d;
    int         mismatches = 0;
    int         n_compared = 0;
    int         cycles = 0;

    synth_cal_test_regs #(.PART_ID(PART), .REV_ID(REV)) u_synth_cal_test_regs (
        .clock, .srst, .sclkPin, .chipSelectN, .serialIn, .serialOut, .serialOutOe,
        .calUpdate, .calCoarseResult, .radioIdle, .vcoCoarseTune, .synthCalControl,
        .vcoSelectStageEnable, .synthFactoryTest, .productionTest, .testSettingsA,
        .testSettingsB, .testSettingsC, .tempSensorEnable);
    spi_host_model u_spi_host_model (
        .clock, .sclkPin, .chipSelectN, .serialIn, .serialOut, .rdDone, .rdByte);

    task automatic report_and_stop();
        if (expQ.size() != 0) begin
            mismatches++;
            $display("Error at %0t: %0d reads never finished", $time, expQ.size());
        end
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check_port(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: port %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic check_read(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: read %h, expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [63:0] outSnap();
        return {9'h0, vcoCoarseTune, synthCalControl, vcoSelectStageEnable, synthFactoryTest,
            productionTest, testSettingsA, testSettingsB, testSettingsC, tempSensorEnable};
    endfunction

    task automatic rd(input logic [7:0] hdr, input logic [7:0] exp, input int nBits = 16);
        expQ.push_back(exp);
        u_spi_host_model.xfer(hdr, 8'h00, nBits);
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] data, input int nBits = 16);
        u_spi_host_model.xfer(addr, data, nBits);
    endtask

    // Oldest expected read is matched against each finished read
    always @(posedge rdDone) begin
        check_read(rdByte, expQ.pop_front());
    end

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            $display("Error at %0t: timeout", $time);
            report_and_stop();
        end
    end

    initial begin
        srst = 1'b1;
        calUpdate = 1'b0;
        calCoarseResult = 6'h00;
        radioIdle = 1'b0;
        void'($urandom(32'hdb23));
        repeat (4) @(posedge clock);
        @(negedge clock) srst = 1'b0;
        // Defaults after reset
        check_port(outSnap(), DEF);
        check_port(serialOutOe, 1'b0);
        foreach (ADDRS[i]) rd(8'h80 | ADDRS[i], EXPS[i]);
        // Status space, burst status read does not advance
        rd(8'hf0, PART);
        rd(8'hf1, REV);
        rd(8'hf0, PART, 24);
        rd(8'hb0, 8'h00);
        wr(8'h30, 8'haa);
        rd(8'hf0, PART);
        // Unused bits ignored
        d = 8'(($urandom() & 32'h3f) | 32'hc0);
        wr(8'h25, d);
        check_port(vcoCoarseTune, d[5:0]);
        rd(8'ha5, {2'b00, d[5:0]});
        wr(8'h26, 8'hff);
        rd(8'ha6, 8'h7f);
        // Burst write and burst read over both result fields
        d = 8'($urandom());
        wr(8'h65, d, 24);
        check_port({vcoCoarseTune, synthCalControl}, {d[5:0], d[6:0]});
        rd(8'he5, {1'b0, d[6:0]}, 24);
        // Stage enable both ways
        for (int b = 0; b < 2; b++) begin
            wr(8'h2e, {6'h02, b[0], 1'b1});
            check_port(vcoSelectStageEnable, b[0]);
        end
        // Sensor only while idle; code restored before leaving idle
        wr(8'h2a, `TEMP_SENSOR_CODE);
        check_port(tempSensorEnable, 1'b0);
        @(negedge clock) radioIdle = 1'b1;
        @(negedge clock);
        check_port(tempSensorEnable, 1'b1);
        wr(8'h2a, `RST_PROD_TEST);
        check_port(productionTest, `RST_PROD_TEST);
        check_port(tempSensorEnable, 1'b0);
        @(negedge clock) radioIdle = 1'b0;
        // Save calibration, overwrite it, then restore the saved value
        @(negedge clock);
        calUpdate = 1'b1;
        calCoarseResult = 6'($urandom());
        d = {2'b00, calCoarseResult};
        @(negedge clock) calUpdate = 1'b0;
        check_port(vcoCoarseTune, d[5:0]);
        rd(8'ha5, d);
        wr(8'h25, ~d);
        check_port(vcoCoarseTune, d[5:0] ^ 6'h3f);
        wr(8'h25, d);
        check_port(vcoCoarseTune, d[5:0]);
        // Written register, aborted byte, then mid-run reset
        d = 8'($urandom());
        wr(8'h2c, d);
        check_port(testSettingsC, d);
        u_spi_host_model.xfer(8'h2d, 8'hff, 12);
        check_port(testSettingsB, `RST_TEST_B);
        @(negedge clock) srst = 1'b1;
        repeat (2) @(negedge clock);
        srst = 1'b0;
        check_port(outSnap(), DEF);
        rd(8'hf1, REV);
        rd(8'ha5, {2'h0, `RST_COARSE_TUNE});
        report_and_stop();
    end
endmodule

`default_nettype wire
